/* logic/mne_noise_estimator.sv */
// Noise estimator for X, Y and R demodulator outputs, plus its output FIFO.
// Assumes inputs synchronous to clock; consumer drains via valid/ready.
`timescale 1ns/100ps
`include "mne_defines.svh"

// Output buffer; registered head word so outputs come from flops
module mne_fifo #(
    parameter int W = 48,
    parameter int DEPTH = `MNE_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    // Pointer width; depth is a power of two so pointers wrap freely
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH]; // Storage, no reset needed
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ov_q, ov_d;
    logic [W-1:0] od_q, od_d;
    logic push, load;

    // Full is honest: head register is not counted as a slot
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = ov_q;
    assign out_data = od_q;

    // Pointer, count and head-register next values
    always_comb begin
        push = in_valid && in_ready;
        load = (!ov_q || out_ready) && (cnt_q != '0);
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = load ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        if (load) begin
            ov_d = 1'b1;
            od_d = mem[rd_q];
        end else begin
            ov_d = out_ready ? 1'b0 : ov_q;
            od_d = od_q;
        end
    end

    // Register stage
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
    end

    // Array write; same cycle as pointer advance
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Count can never pass the depth; a slip here would drop words silently
    cnt_bound_a: assert property (@(posedge clock) disable iff (!nrst)
        cnt_q <= DEPTH[AW:0])
        else $error("buffer count above depth");
    // Head word must stand until the consumer takes it
    head_keep_a: assert property (@(posedge clock) disable iff (!nrst)
        ov_q && !out_ready |=> ov_q && $stable(od_q))
        else $error("head word changed before taken");
endmodule // mne_fifo

// Behaviour
// - Separate X, Y, R estimates at 512 Hz.
// - Running mean kept per quantity.
// - Deviation is sample minus current mean.
// - Average absolute deviations gives raw noise.
// - Both averages refreshed every sample.
// - Averaging length 10 to 80 time constants.
// - Fixed Gaussian factor converts MAD to RMS.
// - Divide out ENBW, report per root hertz.
// - Estimation runs whether or not consumed.
// - Sensitivity change never clears estimator state.
module mne_noise_estimator import mne_pkg::*; #(
    parameter int W = `MNE_DATA_W,
    parameter int TICK_CYCLES = `MNE_CLK_HZ / `MNE_RATE_HZ,
    parameter int DEPTH = `MNE_FIFO_DEPTH,
    // Gaussian factor times root(1/ENBW) per time-constant code, Q4.12
    parameter logic [`MNE_SCALE_W-1:0] SCALE_TAB [8] = '{
        16'h1406, 16'h1c5a, 16'h280d, 16'h38b5,
        16'h501a, 16'h716a, 16'ha035, 16'he2d4}
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic signed [W-1:0] inphase_in,
    input wire logic signed [W-1:0] quadrature_in,
    input wire logic signed [W-1:0] magnitude_in,
    input wire logic [`MNE_TC_W-1:0] tc_sel,
    output logic est_valid,
    input wire logic est_ready,
    output logic [W-1:0] inphase_noise_estimate,
    output logic [W-1:0] quadrature_noise_estimate,
    output logic [W-1:0] magnitude_noise_estimate
);
    localparam int FR = `MNE_FRAC_W;
    localparam int AW = W + FR + 2; // Headroom for difference sign
    localparam int CW = $clog2(TICK_CYCLES);
    // Product of the 17-bit MAD integer part and the 16-bit scale
    localparam int PW = W + 1 + `MNE_SCALE_W;
    localparam int NC = `MNE_NCHAN;

    // Sample-rate tick
    logic [CW-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d, upd_q, upd_d;
    logic [`MNE_TC_W-1:0] tc_q, tc_d; // Time-constant code in force
    logic [`MNE_SHIFT_W-1:0] sh;
    logic signed [W-1:0] smp [NC];
    logic [W-1:0] est [NC];
    logic signed [AW-1:0] mean_q [NC];
    logic signed [AW-1:0] mad_q [NC];
    logic signed [AW-1:0] dev [NC];
    logic signed [AW-1:0] absd [NC];
    // Publish stage
    mne_pub_t pub_q, pub_d;
    // Packed as {R, Y, X} so one FIFO word pairs one sample
    logic [NC*W-1:0] pend_q, pend_d, est_word;
    logic fifo_rdy;

    // Gather the three inputs so one generate loop serves them all
    assign smp[`MNE_CH_X] = inphase_in;
    assign smp[`MNE_CH_Y] = quadrature_in;
    assign smp[`MNE_CH_R] = magnitude_in;
    // Length 2^sh samples; codes step the TC so length stays in range
    assign sh = `MNE_SHIFT_W'(`MNE_SHIFT_MIN) + `MNE_SHIFT_W'(tc_q);

    // Saturate scaled MAD to output width
    // Output is unsigned; a MAD beyond full scale pins at all ones
    function automatic logic [W-1:0] mne_sat(input logic [PW-1:0] p);
        logic [PW-1:0] s;
        s = p >> `MNE_SCALE_FRAC;
        mne_sat = (s > PW'({W{1'b1}})) ? {W{1'b1}} : s[W-1:0];
    endfunction

    // Tick, delayed update strobe and time-constant latch
    always_comb begin
        tick_d = (cnt_q == CW'(TICK_CYCLES - 2));
        cnt_d = (cnt_q == CW'(TICK_CYCLES - 1)) ? '0 : cnt_q + 1'b1;
        upd_d = tick_q;
        // New TC sampled only at a sample boundary; state kept as is
        tc_d = tick_q ? tc_sel : tc_q;
    end

    // Tick registers; reset restarts the count, first tick T-1 edges on
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
            upd_q <= 1'b0;
            tc_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            upd_q <= upd_d;
            tc_q <= tc_d;
        end
    end

    // Filters step on the tick edge; publish follows one edge later
    upd_follow_a: assert property (@(posedge clock) disable iff (!nrst)
        tick_q |=> upd_q && !tick_q)
        else $error("update strobe missing after tick");
    tick_phase_a: assert property (@(posedge clock) disable iff (!nrst)
        tick_q |-> cnt_q == CW'(TICK_CYCLES - 1))
        else $error("tick off its counter phase");

    // One filter pair per quantity
    // Each quantity owns its mean and MAD; only the tick, length and scale are shared
    for (genvar g = 0; g < NC; g++) begin : g_ch
        logic signed [AW-1:0] xe, mean_d, mad_d;
        logic [PW-1:0] prod;

        assign xe = {{2{smp[g][W-1]}}, smp[g], {FR{1'b0}}};
        assign dev[g] = xe - mean_q[g];
        assign absd[g] = dev[g][AW-1] ? -dev[g] : dev[g];
        // Scale carries Gaussian factor and ENBW root together
        assign prod = PW'(mad_q[g][W+FR:FR]) * PW'(SCALE_TAB[tc_q]);
        assign est[g] = mne_sat(prod);

        // Exponential averages; no sensitivity input can disturb them
        always_comb begin
            mean_d = mean_q[g];
            mad_d = mad_q[g];
            if (tick_q) begin
                mean_d = mean_q[g] + (dev[g] >>> sh);
                mad_d = mad_q[g] + ((absd[g] - mad_q[g]) >>> sh);
            end
        end

        // Only reset clears state, never a range change
        always_ff @(posedge clock) begin
            if (!nrst) begin
                mean_q[g] <= '0;
                mad_q[g] <= '0;
            end else begin
                mean_q[g] <= mean_d;
                mad_q[g] <= mad_d;
            end
        end

        assign est_word[g*W +: W] = est[g];

        mean_hold_a: assert property (@(posedge clock) disable iff (!nrst)
            !tick_q |=> $stable(mean_q[g]) && $stable(mad_q[g]))
            else $error("average moved between samples");
        mean_up_a: assert property (@(posedge clock) disable iff (!nrst)
            tick_q && dev[g] > 0 |=> mean_q[g] >= $past(mean_q[g]))
            else $error("mean moved away from sample");
        mad_down_a: assert property (@(posedge clock) disable iff (!nrst)
            tick_q && absd[g] <= mad_q[g] |=> mad_q[g] <= $past(mad_q[g]))
            else $error("mad rose on small deviation");
        zero_out_a: assert property (@(posedge clock) disable iff (!nrst)
            mad_q[g] == '0 |-> est[g] == '0)
            else $error("nonzero estimate from zero mad");
    end

    // Publish: newest result overwrites one not yet taken
    // Overwrite trades a lost word for estimation that never stalls
    always_comb begin
        pub_d = pub_q;
        pend_d = pend_q;
        if (upd_q) begin
            pend_d = est_word;
            pub_d = MNE_PUB_HOLD;
        end else begin
            unique case (pub_q)
                MNE_PUB_IDLE: pub_d = MNE_PUB_IDLE;
                MNE_PUB_HOLD: pub_d = fifo_rdy ? MNE_PUB_IDLE : MNE_PUB_HOLD;
            endcase
        end
    end

    // Publish registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pub_q <= MNE_PUB_IDLE;
            pend_q <= '0;
        end else begin
            pub_q <= pub_d;
            pend_q <= pend_d;
        end
    end

    // Back-pressure stalls only the publish stage
    // Latency from sampling edge to a valid head is at least three edges
    mne_fifo #(.W(NC*W), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .in_valid(pub_q == MNE_PUB_HOLD),
        .in_ready(fifo_rdy),
        .in_data(pend_q),
        .out_valid(est_valid),
        .out_ready(est_ready),
        .out_data({magnitude_noise_estimate, quadrature_noise_estimate,
            inphase_noise_estimate})
    );

    // Checks on the tick, the length floor, publishing and the TC latch
    tick_gap_a: assert property (@(posedge clock) disable iff (!nrst)
        tick_q |=> !tick_q [*8])
        else $error("sample ticks too close");
    len_range_a: assert property (@(posedge clock) disable iff (!nrst)
        sh >= `MNE_SHIFT_W'(`MNE_SHIFT_MIN))
        else $error("averaging length below floor");
    pend_set_a: assert property (@(posedge clock) disable iff (!nrst)
        tick_q |-> ##2 pub_q == MNE_PUB_HOLD)
        else $error("result not published");
    tc_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        !tick_q |=> $stable(tc_q))
        else $error("tc changed off boundary");

    // Main scenarios: range switch, back-pressure, overwrite, top code
    tc_change_c: cover property (@(posedge clock) disable iff (!nrst)
        tick_q && tc_sel != tc_q);
    fifo_full_c: cover property (@(posedge clock) disable iff (!nrst)
        !fifo_rdy);
    overwrite_c: cover property (@(posedge clock) disable iff (!nrst)
        upd_q && pub_q == MNE_PUB_HOLD);
    stall_c: cover property (@(posedge clock) disable iff (!nrst)
        est_valid && !est_ready);
    tc_top_c: cover property (@(posedge clock) disable iff (!nrst)
        tick_q && tc_q == '1);
endmodule // mne_noise_estimator

/* logic/mne_defines.svh */
// Constants for the noise estimator: rates, widths, fixed-point formats.
// Assumes inclusion by bare name from the logic folder.
`ifndef MNE_DEFINES_SVH
`define MNE_DEFINES_SVH
`define MNE_CLK_HZ 100000000
`define MNE_RATE_HZ 512
`define MNE_DATA_W 16
`define MNE_FRAC_W 16
`define MNE_TC_W 3
`define MNE_SHIFT_MIN 6
`define MNE_SHIFT_W 4
`define MNE_SCALE_W 16
`define MNE_SCALE_FRAC 12
`define MNE_FIFO_DEPTH 16
`define MNE_NCHAN 3
`define MNE_CH_X 0
`define MNE_CH_Y 1
`define MNE_CH_R 2
`endif

/* logic/mne_pkg.sv */
// Types shared by the noise estimator files.
// Assumes mne_defines.svh is compiled alongside.
package mne_pkg;
    // Publish stage: nothing waiting, or one result held for the FIFO
    typedef enum logic [0:0] {
        MNE_PUB_IDLE = 1'b0,
        MNE_PUB_HOLD = 1'b1
    } mne_pub_t;
endpackage

/* test/mne_demod_model.sv */
// Upstream demodulator stand-in: registers X, Y, R sample levels.
// Assumes one clock; the bench drives new levels between ticks.
`timescale 1ns/100ps
module mne_demod_model (
    input wire logic clock,
    input wire logic [47:0] smp, // Packed {R, Y, X} from the bench
    output logic [47:0] xyr // Levels seen by the estimator
);
    // Output filter levels change only on a clock, like real filter flops
    always_ff @(posedge clock) begin
        xyr <= smp;
    end
endmodule // mne_demod_model

/* test/tb_mne_noise_estimator.sv */
// Bench for the noise estimator: integer model checked per output word.
// Assumes the logic folder is on the include path.
`timescale 1ns/100ps
`include "mne_defines.svh"
`define CHK(n, e, a) begin check_count++; if ((e) !== (a)) begin err_count++; \
    $display("Error %s exp %0h got %0h", n, e, a); end end
module tb_mne_noise_estimator;
    localparam int T = 20; // Short tick keeps the run brief
    localparam logic [15:0] ST [8] = '{16'h1406, 16'h1c5a, 16'h280d, 16'h38b5,
        16'h501a, 16'h716a, 16'ha035, 16'he2d4};
    logic clock, nrst, rdy, vld;
    logic [2:0] tc; // Code offered to the design
    logic [47:0] smp, xyr;
    logic [15:0] nx, ny, nr, rnd;
    logic [15:0] ev [3]; // Expected X, Y, R estimates
    longint mn [3], md [3]; // Model mean and mean deviation, 16 frac bits
    int err_count, check_count, cyc, n, tcq;

    mne_demod_model ups (.clock(clock), .smp(smp), .xyr(xyr));
    mne_noise_estimator #(.TICK_CYCLES(T), .SCALE_TAB(ST)) uut (.clock(clock), .nrst(nrst),
        .inphase_in(xyr[15:0]), .quadrature_in(xyr[31:16]), .magnitude_in(xyr[47:32]),
        .tc_sel(tc), .est_valid(vld), .est_ready(rdy), .inphase_noise_estimate(nx),
        .quadrature_noise_estimate(ny), .magnitude_noise_estimate(nr));

    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // One sample through the model; shift uses the code latched a tick earlier
    task automatic mdl;
        longint x, d;
        for (int c = 0; c < 3; c++) begin
            x = longint'($signed(xyr[16*c +: 16])) <<< 16;
            d = x - mn[c];
            mn[c] += d >>> (6 + tcq);
            md[c] += ((d < 0 ? -d : d) - md[c]) >>> (6 + tcq);
        end
        tcq = tc;
        for (int c = 0; c < 3; c++) begin
            x = ((md[c] >>> 16) * ST[tcq]) >>> 12;
            ev[c] = (x > 65535) ? 16'hffff : x[15:0];
        end
    endtask

    // Take one word at a negedge; new samples follow at the taking edge
    task automatic take(input logic [2:0] t, input bit fresh);
        for (n = 0; n < 200; n++) begin
            @(negedge clock);
            if (vld === 1'b1 && rdy === 1'b1) break;
        end
        // A word that never comes is a failure, not a skipped check
        if (n == 200) begin
            err_count++;
            report_and_stop();
        end
        mdl();
        `CHK("x", ev[0], nx)
        `CHK("y", ev[1], ny)
        `CHK("r", ev[2], nr)
        @(posedge clock);
        tc <= t;
        if (fresh) begin
            rnd = nxt(nxt(nxt(rnd)));
            smp <= {rnd, nxt(rnd), nxt(nxt(rnd))};
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        nrst = 1'b0;
        rdy = 1'b1;
        tc = 3'h0;
        rnd = 16'ha340;
        smp = {rnd, rnd, rnd};
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (30) take(3'h0, 1'b1);
        $display("test stream done");
        // Every code, switching right after a word is taken
        for (int t = 0; t < 8; t++) begin
            repeat (5) take(3'(t), 1'b1);
        end
        $display("test codes done");
        // Consumer stalls; estimation must keep going and buffer
        rdy <= 1'b0;
        repeat (6 * T) @(posedge clock);
        rdy <= 1'b1;
        repeat (6) take(tc, 1'b0);
        $display("test stall done");
        // Long stall overfills the buffer; drain and count the words
        rdy <= 1'b0;
        repeat (25 * T) @(posedge clock);
        rdy <= 1'b1;
        n = 0;
        repeat (60) begin
            @(negedge clock);
            n += (vld === 1'b1);
        end
        `CHK("drain", 1'b1, (n >= 16 && n <= 21))
        // Reset in mid-run clears output and model alike
        @(posedge clock);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("valid", 1'b0, vld)
        @(posedge clock);
        nrst <= 1'b1;
        mn = '{0, 0, 0};
        md = '{0, 0, 0};
        tcq = 0;
        repeat (3) take(3'h2, 1'b1);
        $display("test overflow done");
        report_and_stop();
    end
endmodule // tb_mne_noise_estimator
